/* ptd_params.svh */
// Constants of the PCI target cycle decoder: commands, timing, messages.
// Assumes a 50 MHz PCI-side clock; included by the decoder module and the bench.
// Function
// - Own address block hit: claim, drive device select one clock after frame start.
// - Configuration cycle with select line active: claim with same fast timing.
// - No block hit: claim only after device select idle three clocks.
// - Subtractive claim always uses the fixed slot 4 after frame start, never configurable.
// - Every claimed memory or I/O transaction starts one ISA bus cycle.
// - Decode the four command bits into twelve command types plus one shared reserved type.
// - Interrupt acknowledge is never claimed and never answered.
// - Each special cycle that starts while the decoder is idle is observed and its message examined.
// - Shutdown special cycle or software soft reset raises CPU init request.
// - CPU non-maskable interrupt follows system error or ISA channel check.
`ifndef PTD_PARAMS_SVH
`define PTD_PARAMS_SVH
`define PTD_CMD_INTA 4'h0
`define PTD_CMD_SPECIAL 4'h1
`define PTD_CMD_IO_RD 4'h2
`define PTD_CMD_IO_WR 4'h3
`define PTD_CMD_RSV4 4'h4
`define PTD_CMD_RSV5 4'h5
`define PTD_CMD_MEM_RD 4'h6
`define PTD_CMD_MEM_WR 4'h7
`define PTD_CMD_RSV8 4'h8
`define PTD_CMD_RSV9 4'h9
`define PTD_CMD_CFG_RD 4'hA
`define PTD_CMD_CFG_WR 4'hB
`define PTD_CMD_MEM_RDM 4'hC
`define PTD_CMD_DUAL 4'hD
`define PTD_CMD_MEM_RDL 4'hE
`define PTD_CMD_MEM_WI 4'hF
// Special cycle message code in the low 16 data bits
`define PTD_MSG_SHUTDOWN 16'h0000
// Idle device-select clocks before a subtractive claim
`define PTD_SUB_WAIT 2'h3
`endif

/* ptd_pkg.sv */
// Types of the PCI target cycle decoder.
// Assumes ptd_params.svh is compiled alongside.
package ptd_pkg;
    typedef enum logic [3:0] {
        PTD_INTA, PTD_SPECIAL, PTD_IO_RD, PTD_IO_WR, PTD_MEM_RD, PTD_MEM_WR,
        PTD_CFG_RD, PTD_CFG_WR, PTD_MEM_RDM, PTD_DUAL, PTD_MEM_RDL, PTD_MEM_WI, PTD_RSVD
    } ptd_cmd_t;
    typedef enum {
        PTD_IDLE, PTD_WAIT, PTD_CLAIM, PTD_SPEC
    } ptd_state_t;
endpackage

/* ptd_decoder.sv */
// Target cycle decoder: claims PCI cycles and hands memory/I-O to the ISA side.
// Assumes PCI pins synchronous to i_mclk, active-high inside; address block hit computed outside.
`timescale 1ns/1ps
`include "ptd_params.svh"
module ptd_decoder (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_frame,
    input wire logic [3:0] i_cbe,
    input wire logic [15:0] i_ad_lo,
    input wire logic i_idsel,
    input wire logic i_addr_hit,
    input wire logic i_devsel_in,
    input wire logic i_soft_reset,
    input wire logic i_serr,
    input wire logic i_isa_channel_check,
    output logic o_devsel,
    output logic o_isa_start,
    output logic o_isa_write,
    output logic o_isa_io,
    output logic o_cpu_init,
    output logic o_cpu_nmi,
    output logic o_special_seen
);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic ptd_pkg::ptd_cmd_t ptd_decode(input logic [3:0] c);
        ptd_pkg::ptd_cmd_t r;
        r = ptd_pkg::PTD_RSVD;
        case (c)
            `PTD_CMD_INTA: r = ptd_pkg::PTD_INTA;
            `PTD_CMD_SPECIAL: r = ptd_pkg::PTD_SPECIAL;
            `PTD_CMD_IO_RD: r = ptd_pkg::PTD_IO_RD;
            `PTD_CMD_IO_WR: r = ptd_pkg::PTD_IO_WR;
            `PTD_CMD_MEM_RD: r = ptd_pkg::PTD_MEM_RD;
            `PTD_CMD_MEM_WR: r = ptd_pkg::PTD_MEM_WR;
            `PTD_CMD_CFG_RD: r = ptd_pkg::PTD_CFG_RD;
            `PTD_CMD_CFG_WR: r = ptd_pkg::PTD_CFG_WR;
            `PTD_CMD_MEM_RDM: r = ptd_pkg::PTD_MEM_RDM;
            `PTD_CMD_DUAL: r = ptd_pkg::PTD_DUAL;
            `PTD_CMD_MEM_RDL: r = ptd_pkg::PTD_MEM_RDL;
            `PTD_CMD_MEM_WI: r = ptd_pkg::PTD_MEM_WI;
            default: r = ptd_pkg::PTD_RSVD;
        endcase
        return r;
    endfunction

    ptd_pkg::ptd_state_t state, next_state;
    ptd_pkg::ptd_cmd_t cmd, next_cmd;
    logic frame_d, next_frame_d;
    logic [1:0] idle_cnt, next_idle_cnt;
    logic next_devsel, next_isa_start, next_isa_write, next_isa_io;
    logic next_cpu_init, next_cpu_nmi, next_special_seen;
    logic frame_start;
    ptd_pkg::ptd_cmd_t in_cmd;
    logic mem_or_io;
    logic is_cfg;

    assign frame_start = i_frame && !frame_d;
    assign in_cmd = ptd_decode(i_cbe);
    assign mem_or_io = (cmd == ptd_pkg::PTD_IO_RD) || (cmd == ptd_pkg::PTD_IO_WR) ||
        (cmd == ptd_pkg::PTD_MEM_RD) || (cmd == ptd_pkg::PTD_MEM_WR) || (cmd == ptd_pkg::PTD_MEM_RDM) ||
        (cmd == ptd_pkg::PTD_MEM_RDL) || (cmd == ptd_pkg::PTD_MEM_WI);
    assign is_cfg = (in_cmd == ptd_pkg::PTD_CFG_RD) || (in_cmd == ptd_pkg::PTD_CFG_WR);

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        next_cmd = cmd;
        next_frame_d = i_frame;
        next_idle_cnt = idle_cnt;
        next_devsel = 1'b0;
        next_isa_start = 1'b0;
        next_isa_write = o_isa_write;
        next_isa_io = o_isa_io;
        next_special_seen = 1'b0;
        next_cpu_init = i_soft_reset;
        next_cpu_nmi = i_serr || i_isa_channel_check;
        case (state)
            ptd_pkg::PTD_IDLE: begin
                if (frame_start) begin
                    next_cmd = in_cmd;
                    next_idle_cnt = 2'h0;
                    if (in_cmd == ptd_pkg::PTD_INTA) begin
                        next_state = ptd_pkg::PTD_IDLE;
                    end else if (in_cmd == ptd_pkg::PTD_SPECIAL) begin
                        next_state = ptd_pkg::PTD_SPEC;
                    end else if (is_cfg && i_idsel) begin
                        next_devsel = 1'b1;
                        next_state = ptd_pkg::PTD_CLAIM;
                    end else if (in_cmd == ptd_pkg::PTD_RSVD || is_cfg) begin
                        next_state = ptd_pkg::PTD_IDLE;
                    end else if (i_addr_hit) begin
                        next_devsel = 1'b1;
                        next_state = ptd_pkg::PTD_CLAIM;
                    end else begin
                        next_state = ptd_pkg::PTD_WAIT;
                    end
                end
            end
            ptd_pkg::PTD_WAIT: begin
                if (i_devsel_in) begin
                    next_state = ptd_pkg::PTD_IDLE;
                end else if (idle_cnt == `PTD_SUB_WAIT - 2'h1) begin
                    next_devsel = 1'b1;
                    next_state = ptd_pkg::PTD_CLAIM;
                end else begin
                    next_idle_cnt = idle_cnt + 2'h1;
                end
            end
            ptd_pkg::PTD_CLAIM: begin
                next_devsel = i_frame;
                if (o_devsel && !frame_d && mem_or_io) begin
                    next_isa_start = 1'b1;
                    next_isa_write = (cmd == ptd_pkg::PTD_IO_WR) || (cmd == ptd_pkg::PTD_MEM_WR) ||
                        (cmd == ptd_pkg::PTD_MEM_WI);
                    next_isa_io = (cmd == ptd_pkg::PTD_IO_RD) || (cmd == ptd_pkg::PTD_IO_WR);
                end
                if (o_devsel && !frame_d) begin
                    next_devsel = 1'b0;
                    next_state = ptd_pkg::PTD_IDLE;
                end else if (!o_devsel && !frame_d) begin
                    next_state = ptd_pkg::PTD_IDLE;
                end else begin
                    next_devsel = 1'b1;
                end
            end
            ptd_pkg::PTD_SPEC: begin
                // Message sits on the data phase; take first word seen
                next_special_seen = 1'b1;
                if (i_ad_lo == `PTD_MSG_SHUTDOWN) begin
                    next_cpu_init = 1'b1;
                end
                next_state = ptd_pkg::PTD_IDLE;
            end
            default: next_state = ptd_pkg::PTD_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state <= ptd_pkg::PTD_IDLE;
            cmd <= ptd_pkg::PTD_RSVD;
            frame_d <= 1'b0;
            idle_cnt <= 2'h0;
            o_devsel <= 1'b0;
            o_isa_start <= 1'b0;
            o_isa_write <= 1'b0;
            o_isa_io <= 1'b0;
            o_cpu_init <= 1'b0;
            o_cpu_nmi <= 1'b0;
            o_special_seen <= 1'b0;
        end else begin
            state <= next_state;
            cmd <= next_cmd;
            frame_d <= next_frame_d;
            idle_cnt <= next_idle_cnt;
            o_devsel <= next_devsel;
            o_isa_start <= next_isa_start;
            o_isa_write <= next_isa_write;
            o_isa_io <= next_isa_io;
            o_cpu_init <= next_cpu_init;
            o_cpu_nmi <= next_cpu_nmi;
            o_special_seen <= next_special_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_fast_hit;
        frame_start && i_addr_hit && state == ptd_pkg::PTD_IDLE &&
            (in_cmd == ptd_pkg::PTD_MEM_RD || in_cmd == ptd_pkg::PTD_IO_RD ||
             in_cmd == ptd_pkg::PTD_MEM_WR || in_cmd == ptd_pkg::PTD_IO_WR);
    endsequence
    sequence s_sub_wait;
        frame_start && !i_addr_hit && state == ptd_pkg::PTD_IDLE &&
            in_cmd == ptd_pkg::PTD_MEM_RD ##1 !i_devsel_in [*3];
    endsequence

    property p_fast_claim;
        @(posedge i_mclk) disable iff (i_rst) s_fast_hit |=> o_devsel;
    endproperty
    a_fast_claim: assert property (p_fast_claim) else $error("fast claim missing");

    property p_cfg_claim;
        @(posedge i_mclk) disable iff (i_rst)
            frame_start && state == ptd_pkg::PTD_IDLE && is_cfg && i_idsel |=> o_devsel;
    endproperty
    a_cfg_claim: assert property (p_cfg_claim) else $error("config claim missing");

    property p_sub_claim;
        @(posedge i_mclk) disable iff (i_rst) s_sub_wait |=> o_devsel;
    endproperty
    a_sub_claim: assert property (p_sub_claim) else $error("subtractive claim missing");

    property p_sub_not_early;
        @(posedge i_mclk) disable iff (i_rst)
            frame_start && !i_addr_hit && state == ptd_pkg::PTD_IDLE && in_cmd == ptd_pkg::PTD_MEM_RD
            |=> !o_devsel [*3];
    endproperty
    a_sub_not_early: assert property (p_sub_not_early) else $error("subtractive claim too early");

    property p_isa_start;
        @(posedge i_mclk) disable iff (i_rst) o_isa_start |-> $past(o_devsel) && mem_or_io;
    endproperty
    a_isa_start: assert property (p_isa_start) else $error("isa cycle without claim");

    property p_inta;
        @(posedge i_mclk) disable iff (i_rst)
            frame_start && state == ptd_pkg::PTD_IDLE && in_cmd == ptd_pkg::PTD_INTA |=> !o_devsel [*4];
    endproperty
    a_inta: assert property (p_inta) else $error("interrupt ack claimed");

    property p_special;
        @(posedge i_mclk) disable iff (i_rst)
            frame_start && state == ptd_pkg::PTD_IDLE && in_cmd == ptd_pkg::PTD_SPECIAL |-> ##2 o_special_seen;
    endproperty
    a_special: assert property (p_special) else $error("special cycle missed");

    property p_init;
        @(posedge i_mclk) disable iff (i_rst)
            state == ptd_pkg::PTD_SPEC && i_ad_lo == `PTD_MSG_SHUTDOWN |=> o_cpu_init;
    endproperty
    a_init: assert property (p_init) else $error("shutdown init missing");

    property p_nmi;
        @(posedge i_mclk) disable iff (i_rst) (i_serr || i_isa_channel_check) |=> o_cpu_nmi;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi missing");

    property p_rsvd;
        @(posedge i_mclk) disable iff (i_rst)
            frame_start && state == ptd_pkg::PTD_IDLE && in_cmd == ptd_pkg::PTD_RSVD |=> !o_devsel [*3];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved command claimed");
endmodule // ptd_decoder

/* ptd_pci_agent.sv */
// Model of the PCI masters and other targets around the decoder.
// Assumes one clock; txn is called just after a rising edge.
`timescale 1ns/1ps
module ptd_pci_agent (
    input wire logic i_mclk,
    output logic o_frame,
    output logic [3:0] o_cbe,
    output logic [15:0] o_ad_lo,
    output logic o_idsel,
    output logic o_addr_hit,
    output logic o_devsel_in
);
    initial begin
        o_frame = 1'b0;
        o_cbe = 4'hF;
        o_ad_lo = 16'hA5A5;
        o_idsel = 1'b0;
        o_addr_hit = 1'b0;
        o_devsel_in = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // One transaction of len clocks; oth = slot of another claim, 0 none
    task automatic txn(input logic [3:0] cmd, input logic hit, input logic sel, input int oth,
                       input logic [15:0] msg, input int len);
        int k;
        o_frame = 1'b1;
        o_cbe = cmd;
        o_ad_lo = 16'h1234;
        o_idsel = sel;
        o_addr_hit = hit;
        for (k = 0; k < len; k++) begin
            @(posedge i_mclk);
            #1;
            // Released data and command lines never keep the last value; select and hit are held low
            o_ad_lo = (k == 0) ? msg : ~o_ad_lo;
            o_cbe = ~o_cbe;
            o_idsel = 1'b0;
            o_addr_hit = 1'b0;
            if (k + 1 == oth) o_devsel_in = 1'b1;
            if (k == len - 1) o_frame = 1'b0;
        end
        @(posedge i_mclk);
        #1;
        o_devsel_in = 1'b0;
        o_ad_lo = ~o_ad_lo;
    endtask
endmodule // ptd_pci_agent

/* pci_target_cycle_decoder_tb_top.sv */
// Self-checking bench of the target cycle decoder.
// Assumes the decoder and its agent share one 50 MHz clock.
`timescale 1ns/1ps
`include "ptd_params.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module pci_target_cycle_decoder_tb_top;
    typedef struct {logic [3:0] cmd; logic hit; logic sel; int oth; logic [15:0] msg;
                    int dev; int isa; logic wr; logic io; int spec; int init;} ptd_row_t;
    logic i_mclk, i_rst, i_frame, i_idsel, i_addr_hit, i_devsel_in;
    logic i_soft_reset, i_serr, i_isa_channel_check;
    logic [3:0] i_cbe;
    logic [15:0] i_ad_lo;
    logic o_devsel, o_isa_start, o_isa_write, o_isa_io, o_cpu_init, o_cpu_nmi, o_special_seen;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    // Fields: cmd hit sel oth msg | dev slot (-1 any) isa (-1 any) wr io spec init
    ptd_row_t rows[23] = '{
        '{`PTD_CMD_MEM_RD, 1, 0, 0, 16'h0001, 1, 1, 0, 0, 0, 0},
        '{`PTD_CMD_MEM_WR, 1, 0, 0, 16'h0000, 1, 1, 1, 0, 0, 0},
        '{`PTD_CMD_IO_RD, 0, 0, 0, 16'h0001, 4, 1, 0, 1, 0, 0},
        '{`PTD_CMD_IO_WR, 1, 0, 0, 16'h0001, 1, 1, 1, 1, 0, 0},
        '{`PTD_CMD_IO_WR, 0, 0, 2, 16'h0001, 0, 0, 0, 0, 0, 0},
        '{`PTD_CMD_MEM_RD, 0, 0, 3, 16'h0001, 0, 0, 0, 0, 0, 0},
        '{`PTD_CMD_MEM_WR, 0, 0, 1, 16'h0001, 0, 0, 0, 0, 0, 0},
        '{`PTD_CMD_CFG_RD, 0, 1, 0, 16'h0001, 1, 0, 0, 0, 0, 0},
        '{`PTD_CMD_CFG_WR, 0, 1, 0, 16'h0001, 1, 0, 0, 0, 0, 0},
        '{`PTD_CMD_CFG_WR, 0, 0, 0, 16'h0001, 0, 0, 0, 0, 0, 0},
        '{`PTD_CMD_INTA, 1, 0, 0, 16'h0001, 0, 0, 0, 0, 0, 0},
        '{`PTD_CMD_INTA, 0, 0, 0, 16'h0001, 0, 0, 0, 0, 0, 0},
        '{`PTD_CMD_RSV4, 1, 0, 0, 16'h0001, 0, 0, 0, 0, 0, 0},
        '{`PTD_CMD_RSV5, 0, 0, 0, 16'h0001, 0, 0, 0, 0, 0, 0},
        '{`PTD_CMD_RSV8, 1, 0, 0, 16'h0001, 0, 0, 0, 0, 0, 0},
        '{`PTD_CMD_RSV9, 0, 0, 0, 16'h0001, 0, 0, 0, 0, 0, 0},
        '{`PTD_CMD_SPECIAL, 0, 0, 0, 16'h0000, -1, 0, 0, 0, 1, 1},
        '{`PTD_CMD_SPECIAL, 0, 0, 0, 16'h0002, -1, 0, 0, 0, 1, 0},
        '{`PTD_CMD_MEM_RDM, 0, 0, 0, 16'h0001, 4, 1, 0, 0, 0, 0},
        '{`PTD_CMD_MEM_RDL, 1, 0, 0, 16'h0001, 1, 1, 0, 0, 0, 0},
        '{`PTD_CMD_MEM_WI, 1, 0, 0, 16'h0001, 1, 1, 1, 0, 0, 0},
        '{`PTD_CMD_MEM_RD, 0, 0, 0, 16'h0001, 4, 1, 0, 0, 0, 0},
        '{`PTD_CMD_DUAL, 0, 0, 0, 16'h0001, -1, -1, 0, 0, 0, 0}};
    ptd_pci_agent u_agent (.i_mclk(i_mclk), .o_frame(i_frame), .o_cbe(i_cbe), .o_ad_lo(i_ad_lo),
        .o_idsel(i_idsel), .o_addr_hit(i_addr_hit), .o_devsel_in(i_devsel_in));
    ptd_decoder u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_frame(i_frame), .i_cbe(i_cbe),
        .i_ad_lo(i_ad_lo), .i_idsel(i_idsel), .i_addr_hit(i_addr_hit), .i_devsel_in(i_devsel_in),
        .i_soft_reset(i_soft_reset), .i_serr(i_serr), .i_isa_channel_check(i_isa_channel_check),
        .o_devsel(o_devsel), .o_isa_start(o_isa_start), .o_isa_write(o_isa_write),
        .o_isa_io(o_isa_io), .o_cpu_init(o_cpu_init), .o_cpu_nmi(o_cpu_nmi),
        .o_special_seen(o_special_seen));
    ////////////////////////////////////////////////////////////////
    always #10 i_mclk = ~i_mclk;
    // Ceiling well above 23 rows of 12 clocks
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 1000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Runs one row; t counts clocks from the frame start edge
    task automatic do_row(input ptd_row_t r);
        int t, dev_at, dev_last, n_isa, n_spec, n_init;
        logic wr, io;
        dev_at = -1;
        dev_last = -1;
        n_isa = 0;
        n_spec = 0;
        n_init = 0;
        fork
            u_agent.txn(r.cmd, r.hit, r.sel, r.oth, r.msg, 6);
            for (t = 0; t < 11; t++) begin
                @(posedge i_mclk);
                #2;
                // Registered claim is seen by the bus at the next edge
                if (o_devsel === 1'b1 && dev_at < 0) dev_at = t + 1;
                if (o_devsel === 1'b1) dev_last = t + 1;
                if (o_isa_start === 1'b1) begin
                    n_isa++;
                    wr = o_isa_write;
                    io = o_isa_io;
                end
                if (o_special_seen === 1'b1) n_spec++;
                if (o_cpu_init === 1'b1) n_init++;
            end
        join
        if (r.dev >= 0) `CHK("devsel_at", (r.dev == 0) ? -1 : r.dev, dev_at)
        if (r.dev >= 0) `CHK("devsel_last", (r.dev == 0) ? -1 : 7, dev_last)
        if (r.isa >= 0) `CHK("isa_starts", r.isa, n_isa)
        if (r.isa == 1) `CHK("isa_write", r.wr, wr)
        if (r.isa == 1) `CHK("isa_io", r.io, io)
        `CHK("special_seen", r.spec, n_spec)
        `CHK("init_pulses", r.init, n_init)
        @(posedge i_mclk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        i_mclk = 1'b0;
        i_rst = 1'b1;
        i_soft_reset = 1'b0;
        i_serr = 1'b0;
        i_isa_channel_check = 1'b0;
        repeat (4) @(posedge i_mclk);
        #1;
        `CHK("reset_outputs", 7'h00, {o_devsel, o_isa_start, o_isa_write, o_isa_io, o_cpu_init,
             o_cpu_nmi, o_special_seen})
        i_rst = 1'b0;
        foreach (rows[i]) do_row(rows[i]);
        // Every source combination of the interrupt output
        for (int k = 0; k < 5; k++) begin
            i_serr = k[0];
            i_isa_channel_check = k[1];
            @(posedge i_mclk);
            #1;
            `CHK("cpu_nmi", k[0] | k[1], o_cpu_nmi)
        end
        i_soft_reset = 1'b1;
        @(posedge i_mclk);
        #1;
        `CHK("init_soft", 1'b1, o_cpu_init)
        i_soft_reset = 1'b0;
        @(posedge i_mclk);
        #1;
        `CHK("init_release", 1'b0, o_cpu_init)
        stop_test();
    end
endmodule // pci_target_cycle_decoder_tb_top
